// >>> hdl/tcc_pkg.sv
// Purpose: shared constants and types for the timer compare/capture control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   offsets 0x10..0x1F are channel value words, two bytes each
package tcc_pkg;
  localparam logic [5:0] TOGGLE_EN_OFS    = 6'h07;
  localparam logic [5:0] ACT_HI_OFS       = 6'h08;
  localparam logic [5:0] ACT_LO_OFS       = 6'h09;
  localparam logic [5:0] EDGE_HI_OFS      = 6'h0A;
  localparam logic [5:0] EDGE_LO_OFS      = 6'h0B;
  localparam logic [5:0] IRQ_EN_OFS       = 6'h0C;
  localparam logic [5:0] SYS_CTRL_TWO_OFS = 6'h0D;
  localparam logic [5:0] CH_FLAGS_OFS     = 6'h0E;
  localparam logic [5:0] OVF_FLAGS_OFS    = 6'h0F;
  localparam logic [5:0] COUNTER_HI_OFS   = 6'h04;
  localparam logic [5:0] COUNTER_LO_OFS   = 6'h05;
  localparam logic [5:0] CHAN_BASE_OFS    = 6'h10;
  localparam logic [5:0] CHAN_LAST_OFS    = 6'h1F;
  localparam logic [5:0] FAST_CTRL_OFS    = 6'h06;
  localparam logic [5:0] OVR_MASK_OFS     = 6'h02;
  localparam logic [5:0] OVR_DATA_OFS     = 6'h03;
  localparam logic [5:0] DIR_SEL_OFS      = 6'h00;
  localparam int OVF_IRQ_BIT   = 7;
  localparam int CNT_RESET_BIT = 3;
  localparam int FAST_CLR_BIT  = 4;
  localparam int OVF_FLAG_BIT  = 7;
  localparam int CH7           = 7;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam int PRESCALE_BITS = 7;

  typedef enum logic [1:0] {
    ACT_DISCONNECT = 2'b00,
    ACT_TOGGLE     = 2'b01,
    ACT_CLEAR      = 2'b10,
    ACT_SET        = 2'b11
  } compare_action_t;

  typedef enum logic [1:0] {
    EDGE_OFF     = 2'b00,
    EDGE_RISE    = 2'b01,
    EDGE_FALL    = 2'b10,
    EDGE_ANY     = 2'b11
  } edge_mode_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage

// >>> hdl/timer_compare_capture_control.sv
// Purpose: control, flag and pin-action logic of a six-channel 16-bit timer
// Assumes: 100 MHz clock_in; channel pins arrive asynchronously
// Notes:   channels 7..2 live in bits 7..2; bits 1..0 are unimplemented
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - toggle compare-mode pin on overflow when enabled
// - overflow toggle beats force, yields to ch7; no force compare is built here
// - action bits 00 off,01 toggle,10 low,11 high
// - nonzero action bits make a compare-mode pin an output
// - edge pairs select off, rise, fall, both
// - channel enable gates matching flag to irq
// - overflow enable gates overflow flag to irq
// - reset counter on ch7 compare when enabled
// - ch7 value zero holds counter at zero
// - ch7 value FFFF reset sets no overflow
// - prescaler divides clock by two to select
// - new prescale applies when stages all zero
// - event sets flag, write one clears
// - fast clear by channel register access
// - fast clear overflow by counter access
// - overflow flag set on counter wrap
// - overflow flag cleared writing bit seven
// - ch7 compare beats channels 6:2 masked
// - ch7 compare drives masked pins to data
// - capture latches counter, compare match acts
module timer_compare_capture_control #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  // register port
  input  wire logic [5:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // channel pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_n_out,
  // interrupt request
  output logic             irq_out
);
  // the bit-per-channel register layout only serves eight channel slots
  if (CHANNELS != 8) begin : g_bad_channels
    $error("CHANNELS must be 8");
  end

  tcc_pkg::reg_req_t req;
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // control registers
  logic [7:0]  dir_sel_ff;
  logic [7:0]  ovr_mask_ff;
  logic [7:0]  ovr_data_ff;
  logic [7:0]  fast_ctrl_ff;
  logic [7:0]  toggle_en_ff;
  logic [7:0]  act_hi_ff;
  logic [7:0]  act_lo_ff;
  logic [7:0]  edge_hi_ff;
  logic [7:0]  edge_lo_ff;
  logic [7:0]  irq_en_ff;
  logic [7:0]  sys_two_ff;
  logic [7:0]  ch_flag_ff;
  logic [7:0]  ovf_flag_ff;
  logic [15:0] counter_ff;
  logic [15:0] chan_ff [2:7];
  logic [7:0]  pin_val_ff;
  logic [7:0]  sync1_ff;
  logic [7:0]  sync2_ff;
  logic [7:0]  sync3_ff;
  logic [6:0]  pre_cnt_ff;
  logic [2:0]  pre_sel_ff;

  wire fast_clr = fast_ctrl_ff[tcc_pkg::FAST_CLR_BIT];
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  // one block per control register; all bits are stored, unused ones too
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dir_sel_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::DIR_SEL_OFS)) begin
      dir_sel_ff <= req.wdata;
    end
  end

  // mask also enables compare-mode pin drivers; data only matters on a channel 7 compare
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ovr_mask_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::OVR_MASK_OFS)) begin
      ovr_mask_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ovr_data_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::OVR_DATA_OFS)) begin
      ovr_data_ff <= req.wdata;
    end
  end

  // only the fast clear bit is acted on here
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fast_ctrl_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::FAST_CTRL_OFS)) begin
      fast_ctrl_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      toggle_en_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::TOGGLE_EN_OFS)) begin
      toggle_en_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_hi_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::ACT_HI_OFS)) begin
      act_hi_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_lo_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::ACT_LO_OFS)) begin
      act_lo_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      edge_hi_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::EDGE_HI_OFS)) begin
      edge_hi_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      edge_lo_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::EDGE_LO_OFS)) begin
      edge_lo_ff <= req.wdata;
    end
  end

  // enables of channels 1:0 are stored but gate flags that never set
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_en_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::IRQ_EN_OFS)) begin
      irq_en_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_two_ff <= tcc_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, tcc_pkg::SYS_CTRL_TWO_OFS)) begin
      sys_two_ff <= req.wdata;
    end
  end

  // prescaler: select is taken only when every stage is zero
  wire [2:0] sel_now = sys_two_ff[2:0];
  wire       pre_zero = (pre_cnt_ff == 7'h00);
  logic [6:0] pre_mask;
  always_comb begin
    pre_mask = 7'((8'h01 << pre_sel_ff) - 8'h01);
  end
  wire tick = ((pre_cnt_ff & pre_mask) == pre_mask);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_cnt_ff <= 7'h00;
      pre_sel_ff <= 3'h0;
    end else begin
      pre_cnt_ff <= tick ? 7'h00 : pre_cnt_ff + 7'h01;
      if (pre_zero) pre_sel_ff <= sel_now;
    end
  end

  // counter and compare matches
  logic [7:0] match;
  always_comb begin
    match = 8'h00;
    for (int i = 2; i <= 7; i++) begin
      match[i] = dir_sel_ff[i] && tick && (chan_ff[i] == counter_ff);
    end
  end
  wire ch7_reset = sys_two_ff[tcc_pkg::CNT_RESET_BIT] && match[tcc_pkg::CH7];
  wire wrap      = tick && !ch7_reset && (counter_ff == tcc_pkg::CNT_MAX);
  wire cnt_acc   = (req.wr || req.rd) && (hit(req.addr, tcc_pkg::COUNTER_HI_OFS) ||
                   hit(req.addr, tcc_pkg::COUNTER_LO_OFS));

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      counter_ff <= tcc_pkg::CNT_ZERO;
    end else if (ch7_reset) begin
      counter_ff <= tcc_pkg::CNT_ZERO;
    end else if (tick) begin
      counter_ff <= counter_ff + 16'h0001;
    end
  end

  // pin synchroniser and capture edges
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic [7:0] capture;
  logic [15:0] edge_all;
  assign edge_all = {edge_hi_ff, edge_lo_ff};
  always_comb begin
    capture = 8'h00;
    for (int i = 2; i <= 7; i++) begin
      // compare-mode channels never capture, whatever their edge bits say
      case (tcc_pkg::edge_mode_t'(edge_all[2*i+1 -: 2]))
        tcc_pkg::EDGE_RISE: capture[i] = !dir_sel_ff[i] && sync2_ff[i] && !sync3_ff[i];
        tcc_pkg::EDGE_FALL: capture[i] = !dir_sel_ff[i] && !sync2_ff[i] && sync3_ff[i];
        tcc_pkg::EDGE_ANY:  capture[i] = !dir_sel_ff[i] && (sync2_ff[i] != sync3_ff[i]);
        default:            capture[i] = 1'b0;
      endcase
    end
  end

  // channel value registers; written directly only in compare mode
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 2; i <= 7; i++) chan_ff[i] <= tcc_pkg::CNT_ZERO;
    end else begin
      for (int i = 2; i <= 7; i++) begin
        if (capture[i]) begin
          chan_ff[i] <= counter_ff;
        end else if (req.wr && dir_sel_ff[i] && req.addr[5:4] == 2'b01 &&
                     req.addr[3:1] == 3'(i)) begin
          if (req.addr[0]) chan_ff[i][7:0] <= req.wdata;
          else             chan_ff[i][15:8] <= req.wdata;
        end
      end
    end
  end

  // flags: set beats any clear in the same cycle
  logic [7:0] ch_clr;
  always_comb begin
    ch_clr = 8'h00;
    if (req.wr && hit(req.addr, tcc_pkg::CH_FLAGS_OFS)) ch_clr = req.wdata;
    for (int i = 2; i <= 7; i++) begin
      if (fast_clr && req.addr[5:4] == 2'b01 && req.addr[3:1] == 3'(i) &&
          ((req.rd && !dir_sel_ff[i]) || (req.wr && dir_sel_ff[i])))
        ch_clr[i] = 1'b1;
    end
  end
  wire ovf_clr = (req.wr && hit(req.addr, tcc_pkg::OVF_FLAGS_OFS) &&
                  req.wdata[tcc_pkg::OVF_FLAG_BIT]) || (fast_clr && cnt_acc);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ch_flag_ff  <= tcc_pkg::REG_RESET;
      ovf_flag_ff <= tcc_pkg::REG_RESET;
    end else begin
      ch_flag_ff  <= ((ch_flag_ff & ~ch_clr) | match | capture) & 8'hFC;
      ovf_flag_ff[tcc_pkg::OVF_FLAG_BIT] <= wrap ||
        (ovf_flag_ff[tcc_pkg::OVF_FLAG_BIT] && !ovf_clr);
    end
  end

  // pin actions, lowest priority first
  logic [15:0] act_all;
  assign act_all = {act_hi_ff, act_lo_ff};
  logic [7:0] nxt_pin_val;
  always_comb begin
    nxt_pin_val = pin_val_ff;
    for (int i = 2; i <= 7; i++) begin
      if (match[i] && !(match[tcc_pkg::CH7] && ovr_mask_ff[i])) begin
        case (tcc_pkg::compare_action_t'(act_all[2*i+1 -: 2]))
          tcc_pkg::ACT_TOGGLE: nxt_pin_val[i] = !pin_val_ff[i];
          tcc_pkg::ACT_CLEAR:  nxt_pin_val[i] = 1'b0;
          tcc_pkg::ACT_SET:    nxt_pin_val[i] = 1'b1;
          default:             ;
        endcase
      end
      if (wrap && toggle_en_ff[i] && dir_sel_ff[i])
        nxt_pin_val[i] = !pin_val_ff[i];
      if (match[tcc_pkg::CH7] && ovr_mask_ff[i])
        nxt_pin_val[i] = ovr_data_ff[i];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_val_ff   <= 8'h00;
      pin_out      <= 8'h00;
      pin_oe_n_out <= 8'hFF;
      irq_out      <= 1'b0;
    end else begin
      pin_val_ff <= nxt_pin_val;
      pin_out    <= nxt_pin_val;
      for (int i = 0; i < 8; i++) begin
        pin_oe_n_out[i] <= !(i >= 2 && dir_sel_ff[i] &&
          (act_all[2*i+1 -: 2] != 2'b00 || ovr_mask_ff[i]));
      end
      irq_out <= |(ch_flag_ff & irq_en_ff) ||
        (ovf_flag_ff[tcc_pkg::OVF_FLAG_BIT] && sys_two_ff[tcc_pkg::OVF_IRQ_BIT]);
    end
  end

  // read data, one cycle after the strobe
  // counter bytes are read live: no snapshot, so a carry can split them
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (req.addr)
      tcc_pkg::DIR_SEL_OFS:      rd_mux = dir_sel_ff;
      tcc_pkg::OVR_MASK_OFS:     rd_mux = ovr_mask_ff;
      tcc_pkg::OVR_DATA_OFS:     rd_mux = ovr_data_ff;
      tcc_pkg::COUNTER_HI_OFS:   rd_mux = counter_ff[15:8];
      tcc_pkg::COUNTER_LO_OFS:   rd_mux = counter_ff[7:0];
      tcc_pkg::FAST_CTRL_OFS:    rd_mux = fast_ctrl_ff;
      tcc_pkg::TOGGLE_EN_OFS:    rd_mux = toggle_en_ff;
      tcc_pkg::ACT_HI_OFS:       rd_mux = act_hi_ff;
      tcc_pkg::ACT_LO_OFS:       rd_mux = act_lo_ff;
      tcc_pkg::EDGE_HI_OFS:      rd_mux = edge_hi_ff;
      tcc_pkg::EDGE_LO_OFS:      rd_mux = edge_lo_ff;
      tcc_pkg::IRQ_EN_OFS:       rd_mux = irq_en_ff;
      tcc_pkg::SYS_CTRL_TWO_OFS: rd_mux = sys_two_ff;
      tcc_pkg::CH_FLAGS_OFS:     rd_mux = ch_flag_ff;
      tcc_pkg::OVF_FLAGS_OFS:    rd_mux = ovf_flag_ff;
      default: begin
        if (req.addr[5:4] == 2'b01 && req.addr[3:1] >= 3'd2)
          rd_mux = req.addr[0] ? chan_ff[req.addr[3:1]][7:0]
                               : chan_ff[req.addr[3:1]][15:8];
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else begin
      // idle read data is held at zero so stale values never leak
      rdata_out <= req.rd ? rd_mux : 8'h00;
    end
  end
endmodule

// >>> testbench/timer_compare_capture_control_monitor.sv
// Purpose: port-level checks for the timer compare/capture control block
// Assumes: control registers shadowed from register-port writes
// Notes:   a flag clear racing a coincident event is kept rare by the bench
`timescale 1ns/100ps
module tcc_monitor (
  // clock, reset, register port
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  // pins and interrupt
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n_out,
  input wire logic       irq_out
);
  logic [7:0]  sh_ff [16];
  logic [1:0]  quiet_ff;
  logic        rd_q_ff;
  logic [5:0]  rd_a_ff;
  logic [15:0] act;
  logic [7:0]  exp_oe_n;
  logic [7:0]  m;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sh_ff    <= '{default: 8'h00};
      quiet_ff <= 2'h0;
      rd_q_ff  <= 1'b0;
      rd_a_ff  <= 6'h00;
    end else begin
      if (wr_in && addr_in < 6'h0E)
        sh_ff[addr_in[3:0]] <= wdata_in;
      quiet_ff <= wr_in ? 2'h0 : ((quiet_ff == 2'h3) ? 2'h3 : quiet_ff + 2'h1);
      rd_q_ff  <= rd_in;
      rd_a_ff  <= addr_in;
    end
  end
  assign act = {sh_ff[8], sh_ff[9]};
  // unimplemented low channels are left out of the readback compare
  assign m = (rd_a_ff == 6'h08 || rd_a_ff == 6'h0A) ? 8'hFF :
             (rd_a_ff == 6'h09 || rd_a_ff == 6'h0B) ? 8'hF0 :
             (rd_a_ff == 6'h0D) ? 8'h8F : 8'hFC;
  always_comb begin
    exp_oe_n = 8'hFF;
    for (int i = 2; i < 8; i++) begin
      exp_oe_n[i] = !(sh_ff[0][i] && (act[2*i+:2] != 2'h0 || sh_ff[2][i]));
    end
  end
  AST_RDATA_IDLE: assert property (!rd_q_ff |-> rdata_out == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_UNMAPPED: assert property (rd_q_ff && rd_a_ff == 6'h3F |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_READBACK: assert property (rd_q_ff && rd_a_ff inside {[6'h07:6'h0D]}
    |-> (rdata_out & m) == (sh_ff[rd_a_ff[3:0]] & m)) else $error("control readback wrong");
  AST_PIN_ENABLE: assert property (quiet_ff == 2'h3
    |-> pin_oe_n_out[7:2] == exp_oe_n[7:2]) else $error("pin enable wrong");
  AST_IRQ_MASKED: assert property (quiet_ff == 2'h3 && sh_ff[12][7:2] == 6'h00
    && !sh_ff[13][7] |-> !irq_out) else $error("irq with all enables clear");
  AST_IRQ_FLAG: assert property ((rd_in && addr_in == tcc_pkg::CH_FLAGS_OFS) ##1
    (!wr_in && !rd_in && (rdata_out[7:2] & sh_ff[12][7:2]) != 6'h00) |=> irq_out)
    else $error("enabled flag without irq");
  AST_CH_CLEAR: assert property ((wr_in && addr_in == tcc_pkg::CH_FLAGS_OFS) ##2
    (rd_in && addr_in == tcc_pkg::CH_FLAGS_OFS) |=> (rdata_out & $past(wdata_in, 3) & 8'hFC) == 0)
    else $error("channel flag not cleared");
  AST_OVF_CLEAR: assert property ((wr_in && addr_in == tcc_pkg::OVF_FLAGS_OFS
    && wdata_in[7]) ##2 (rd_in && addr_in == tcc_pkg::OVF_FLAGS_OFS) |=> !rdata_out[7])
    else $error("overflow flag not cleared");
endmodule
bind timer_compare_capture_control tcc_monitor mon_u (.clock_in, .resetn_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .pin_in, .pin_out, .pin_oe_n_out, .irq_out);

// >>> testbench/timer_compare_capture_control_test.sv
// Purpose: directed register-port bench for the timer compare/capture control block
// Assumes: 100 MHz clock, counter at divide-by-1 wraps well inside the run
// Notes:   counter halves are read high then low, so a carry between them is possible
`timescale 1ns/100ps
module timer_compare_capture_control_test;
  logic        clock_in;
  logic        resetn_in;
  logic [5:0]  addr_in;
  logic [7:0]  wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  rdata_out;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe_n_out;
  logic        irq_out;
  int          fail_count;
  int          n_compared;
  logic [7:0]  v;
  logic [7:0]  c0;
  logic [7:0]  c1;
  logic [15:0] t;
  timer_compare_capture_control dut_u (.clock_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .pin_in, .pin_out, .pin_oe_n_out, .irq_out);
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    d = rdata_out;
    @(posedge clock_in);
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    rd(a, v);
    chk(v & m, e, "register read");
  endtask
  // bounded wait: bit 0..7 of pin_out, 8 for irq_out
  task automatic wt(input int w, input logic l);
    int n;
    n = 0;
    @(negedge clock_in);
    while (((w < 8) ? pin_out[w] : irq_out) !== l) begin
      n++;
      if (n > 70000) begin
        fail_count++;
        $display("[FAIL] %0t wait timeout", $time);
        results();
      end
      @(negedge clock_in);
    end
    @(posedge clock_in);
  endtask
  initial begin
    resetn_in = 1'b0;
    addr_in = 6'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    pin_in = 8'h00;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    for (int a = 7; a < 16; a++) rc(a[5:0], 8'h00, 8'hFC);
    rc(6'h3F, 8'h00, 8'hFF);
    chk(pin_oe_n_out, 8'hFF, "pins released");
    for (int a = 7; a < 13; a++) begin
      wr(a[5:0], (8'h5A + a[7:0]) & 8'hFC);
      rc(a[5:0], (8'h5A + a[7:0]) & ((a == 9 || a == 11) ? 8'hF0 : 8'hFC),
         (a == 9 || a == 11) ? 8'hF0 : 8'hFC);
      wr(a[5:0], 8'h00);
    end
    $display("test reset and readback done");
    wr(6'h00, 8'hFC);
    wr(6'h08, 8'hE4);
    wr(6'h02, 8'h04);
    repeat (4) @(posedge clock_in);
    chk(pin_oe_n_out & 8'hFC, 8'h18, "pin enables");
    wr(6'h02, 8'h00);
    wr(6'h08, 8'h00);
    wr(6'h00, 8'h80);
    repeat (3) @(posedge clock_in);
    chk(pin_oe_n_out, 8'hFF, "accumulator pin released");
    $display("test pin enable done");
    for (int k = 0; k < 4; k++) begin
      wr(6'h0B, {2'b00, k[1:0], 4'h0});
      wr(6'h0E, 8'h04);
      pin_in <= 8'h04;
      repeat (6) @(posedge clock_in);
      rc(6'h0E, {5'b0, k[0], 2'b0}, 8'h04);
      wr(6'h0E, 8'h04);
      pin_in <= 8'h00;
      repeat (6) @(posedge clock_in);
      rc(6'h0E, {5'b0, k[1], 2'b0}, 8'h04);
    end
    wr(6'h0B, 8'h00);
    $display("test capture edges done");
    for (int p = 0; p < 7; p += 3) begin
      wr(6'h0D, p[7:0]);
      repeat (130) @(posedge clock_in);
      rd(6'h05, c0);
      repeat (62) @(posedge clock_in);
      rd(6'h05, c1);
      chk(c1 - c0, 8'd64 >> p, "prescaled count");
    end
    $display("test prescaler done");
    wr(6'h0D, 8'h80);
    wr(6'h00, 8'h20);
    wr(6'h07, 8'h20);
    c0 = pin_out;
    wt(8, 1'b1);
    repeat (2) @(posedge clock_in);
    chk({7'h0, pin_out[5]}, {7'h0, ~c0[5]}, "toggle on overflow");
    rc(6'h0F, 8'h80, 8'h80);
    wr(6'h0F, 8'h80);
    rc(6'h0F, 8'h00, 8'h80);
    chk({7'h0, irq_out}, 8'h00, "overflow irq dropped");
    wr(6'h07, 8'h00);
    $display("test overflow done");
    wr(6'h0E, 8'hFC);
    wr(6'h0D, 8'h08);
    wr(6'h00, 8'hC0);
    wr(6'h02, 8'h40);
    wr(6'h03, 8'h40);
    wr(6'h08, 8'hE0);
    wr(6'h1C, 8'h80);
    rd(6'h04, c1);
    rd(6'h05, c0);
    t = {c1, c0} + 16'h0080;
    wr(6'h1E, t[15:8]);
    wr(6'h1F, t[7:0]);
    wt(7, 1'b1);
    chk({7'h0, pin_out[6]}, 8'h01, "override data on pin");
    rc(6'h04, 8'h00, 8'hFF);
    rc(6'h05, 8'h00, 8'hE0);
    wr(6'h0C, 8'h80);
    rc(6'h0E, 8'h80, 8'h80);
    chk({7'h0, irq_out}, 8'h01, "channel irq");
    wr(6'h0E, 8'h80);
    rc(6'h0E, 8'h00, 8'h80);
    chk({7'h0, irq_out}, 8'h00, "channel irq dropped");
    wr(6'h0C, 8'h00);
    $display("test compare done");
    results();
  end
endmodule
